/* File: bench/tcc_capture_compare_bench.sv */
// Self-checking bench for the timer capture and compare block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

module tcc_capture_compare_bench;
    localparam logic [15:0] CNT_TOP = 16'h00ff;
    logic clock = 1'b0;
    logic reset = 1'b1;
    tcc_pkg::tcc_bus_req_t req = '0;
    logic [7:0] read_data;
    logic capture_pin = 1'b0;
    logic comparator_output = 1'b0;
    logic capture_irq_ack = 1'b0;
    logic [1:0] compare_irq_ack = 2'h0;
    logic run = 1'b0;
    logic load = 1'b0;
    logic [15:0] load_value = 16'h0000;
    logic [15:0] timer_count, capture_top_value, compare_a_top_value, w;
    logic timer_tick, at_top, at_bottom, counter_write, capture_irq;
    logic [1:0] compare_irq, compare_output_state, compare_match;
    logic [7:0] d;
    int n_fail = 0;
    int checks_done = 0;
    int n;

    tcc_counter_model CNT (.clock(clock), .reset(reset), .run(run), .load(load), .load_value(load_value),
        .top(CNT_TOP), .timer_count(timer_count), .timer_tick(timer_tick), .at_top(at_top),
        .at_bottom(at_bottom), .counter_write(counter_write));

    tcc_capture_compare DUT (.clock(clock), .reset(reset), .bus_req(req), .read_data(read_data),
        .capture_pin(capture_pin), .comparator_output(comparator_output), .timer_count(timer_count),
        .timer_tick(timer_tick), .at_top(at_top), .at_bottom(at_bottom), .counter_write(counter_write),
        .capture_irq_ack(capture_irq_ack), .compare_irq_ack(compare_irq_ack), .capture_irq(capture_irq),
        .compare_irq(compare_irq), .compare_output_state(compare_output_state),
        .compare_match(compare_match), .capture_top_value(capture_top_value),
        .compare_a_top_value(compare_a_top_value));

    // 40 MHz system clock
    initial begin
        forever #12.5 clock = ~clock;
    end

    // Single-cycle strobes, released on the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        req <= '{addr: a, wdata: v, write_strobe: 1'b1, read_strobe: 1'b0};
        @(posedge clock);
        req.write_strobe <= 1'b0;
    endtask

    // High byte then low byte on adjacent cycles, as the latch expects
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock);
        req <= '{addr: a + 8'h01, wdata: v[15:8], write_strobe: 1'b1, read_strobe: 1'b0};
        @(posedge clock);
        req <= '{addr: a, wdata: v[7:0], write_strobe: 1'b1, read_strobe: 1'b0};
        @(posedge clock);
        req.write_strobe <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, write_strobe: 1'b0, read_strobe: 1'b1};
        @(posedge clock);
        req.read_strobe <= 1'b0;
        #1 v = read_data;
    endtask

    // Low byte first so the high byte comes from the latch
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, write_strobe: 1'b0, read_strobe: 1'b1};
        @(posedge clock);
        req.addr <= a + 8'h01;
        #1 v[7:0] = read_data;
        @(posedge clock);
        req.read_strobe <= 1'b0;
        #1 v[15:8] = read_data;
    endtask

    task automatic load_cnt(input logic [15:0] v);
        @(posedge clock);
        load <= 1'b1;
        load_value <= v;
        @(posedge clock);
        load <= 1'b0;
    endtask

    // Starts on the edge a load ends, so the first tick meets the block
    task automatic ticks(input int k);
        run <= 1'b1;
        repeat (k) @(posedge clock);
        run <= 1'b0;
    endtask

    // Bit 0 acks capture, bits 2:1 ack compare A and B
    task automatic ack(input logic [2:0] m);
        @(posedge clock);
        capture_irq_ack <= m[0];
        compare_irq_ack <= m[2:1];
        @(posedge clock);
        capture_irq_ack <= 1'b0;
        compare_irq_ack <= 2'h0;
    endtask

    // Move a trigger line with the counter frozen; n counts cycles to the request
    task automatic capt(input logic src, input logic lvl, input logic [15:0] v);
        load_cnt(v);
        @(posedge clock);
        if (src) comparator_output <= lvl;
        else capture_pin <= lvl;
        n = 0;
        while (capture_irq !== 1'b1 && n < 30) begin
            @(posedge clock);
            #1 n++;
        end
    endtask

    task automatic end_of_test;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #(25 * 20000);
        n_fail++;
        end_of_test;
    end

    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        // Reset contents, unmapped place reads zero
        rd16(8'h00, w); `CHK(w, 16'h0000)
        rd(8'h0a, d); `CHK(d, 8'h00)
        rd(8'h3f, d); `CHK(d, 8'h00)
        // Compare A direct in normal mode
        wr16(8'h02, 16'h1234);
        rd(8'h03, d); `CHK(d, 8'h12)
        rd(8'h02, d); `CHK(d, 8'h34)
        `CHK(compare_a_top_value, 16'h1234)
        // Compare B direct; latch reloaded by a capture read first
        wr16(8'h04, 16'h8001);
        rd16(8'h00, w); `CHK(w, 16'h0000)
        rd16(8'h04, w); `CHK(w, 16'h8001)
        // Load equal to compare: first tick must not match
        load_cnt(16'h1234);
        ticks(1);
        rd(8'h0a, d); `CHK(d, 8'h00)
        load_cnt(16'h1233);
        ticks(2);
        #1 `CHK(compare_match, 2'b01)
        rd(8'h0a, d); `CHK(d, 8'h02)
        wr(8'h09, 8'h02);
        repeat (2) @(posedge clock);
        #1 `CHK(compare_irq, 2'b01)
        ack(3'b010);
        rd(8'h0a, d); `CHK(d, 8'h00)
        // Force with every output mode code
        wr(8'h06, 8'h01); wr(8'h08, 8'h01);
        rd(8'h0c, d); `CHK(d, 8'h01)
        rd(8'h0a, d); `CHK(d, 8'h00)
        wr(8'h06, 8'h00); wr(8'h08, 8'h01);
        rd(8'h0c, d); `CHK(d, 8'h01)
        wr(8'h06, 8'h02); wr(8'h08, 8'h01);
        rd(8'h0c, d); `CHK(d, 8'h00)
        wr(8'h06, 8'h07); wr(8'h08, 8'h03);
        rd(8'h0c, d); `CHK(d, 8'h03)
        `CHK(compare_output_state, 2'b11)
        // PWM mode: state kept, force ignored, compare buffered to TOP
        wr(8'h07, 8'h0f);
        rd(8'h0c, d); `CHK(d, 8'h03)
        wr(8'h06, 8'h0a); wr(8'h08, 8'h03);
        rd(8'h0c, d); `CHK(d, 8'h03)
        wr16(8'h02, 16'h0010);
        rd(8'h02, d); `CHK(d, 8'h10)
        `CHK(compare_a_top_value, 16'h1234)
        load_cnt(CNT_TOP);
        ticks(1);
        repeat (2) @(posedge clock);
        #1 `CHK(compare_a_top_value, 16'h0010)
        // Captures in normal mode, rising edge, irq on
        wr(8'h07, 8'h40); wr(8'h0a, 8'h07); wr(8'h09, 8'h01);
        capt(1'b0, 1'b1, 16'habcd); `CHK((n >= 3 && n <= 6), 1'b1)
        ack(3'b001);
        rd(8'h0a, d); `CHK(d, 8'h00)
        capt(1'b0, 1'b0, 16'h5555); `CHK(n, 30)
        capt(1'b0, 1'b1, 16'h5678); `CHK((n >= 3 && n <= 6), 1'b1)
        ack(3'b001);
        wr16(8'h00, 16'h7766);
        rd16(8'h00, w); `CHK(w, 16'h5678)
        // Falling edge select, pin driven as a port level
        wr(8'h07, 8'h00);
        capt(1'b0, 1'b0, 16'h2222); `CHK((n >= 3 && n <= 6), 1'b1)
        ack(3'b001);
        rd16(8'h00, w); `CHK(w, 16'h2222)
        // Comparator as trigger, spurious flag cleared by software
        wr(8'h07, 8'h40); wr(8'h0b, 8'h01); wr(8'h0a, 8'h01);
        capt(1'b1, 1'b1, 16'h4444); `CHK((n >= 3 && n <= 6), 1'b1)
        ack(3'b001);
        rd16(8'h00, w); `CHK(w, 16'h4444)
        wr(8'h0b, 8'h00); wr(8'h0a, 8'h01);
        // Filter drops a short glitch, then adds delay
        wr(8'h07, 8'hc0);
        @(posedge clock) capture_pin <= 1'b1;
        repeat (2) @(posedge clock);
        capture_pin <= 1'b0;
        repeat (20) @(posedge clock);
        #1 `CHK(capture_irq, 1'b0)
        capt(1'b0, 1'b1, 16'h3333); `CHK((n >= 7 && n <= 11), 1'b1)
        ack(3'b001);
        rd16(8'h00, w); `CHK(w, 16'h3333)
        // Capture-as-TOP mode: no captures, register writable
        wr(8'h07, 8'h4c);
        capt(1'b0, 1'b0, 16'h6666); `CHK(n, 30)
        capt(1'b0, 1'b1, 16'h7777); `CHK(n, 30)
        wr16(8'h00, 16'h9abc);
        repeat (2) @(posedge clock);
        #1 `CHK(capture_top_value, 16'h9abc)
        end_of_test;
    end
endmodule

`default_nettype wire

/* File: bench/tcc_counter_model.sv */
// Behavioural counter unit that feeds count, tick and extremes to the block
`timescale 1ns/1ps
`default_nettype none

module tcc_counter_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_value,
    input wire logic [15:0] top,
    output logic [15:0] timer_count,
    output logic timer_tick,
    output logic at_top,
    output logic at_bottom,
    output logic counter_write
);
    // One tick per system cycle while running; stopped counter still loads
    assign timer_tick = run;
    assign counter_write = load;
    assign at_top = (timer_count == top);
    assign at_bottom = (timer_count == 16'h0000);

    // Host load wins over counting, as a real counter write does
    always_ff @(posedge clock) begin
        if (reset) begin
            timer_count <= 16'h0000;
        end else if (load) begin
            timer_count <= load_value;
        end else if (run) begin
            timer_count <= at_top ? 16'h0000 : timer_count + 16'h0001;
        end
    end
endmodule

`default_nettype wire

/* File: hdl/tcc_capture_compare.sv */
// Input capture unit and two output compare units of a 16-bit timer
// Functional notes
// - Qualified trigger edge copies counter to capture
// - Capture flag set in same cycle as copy
// - Capture flag raises irq; ack or W1C clears
// - Capture low read loads latch; high returns latch
// - Capture register writable only in capture-TOP modes
// - Trigger select bit; host clears spurious flag
// - Trigger inputs synchronized, then edge detected
// - Filter needs four equal samples to change
// - Captures disabled in capture-TOP waveform modes
// - Each new capture overwrites the previous value
// - Pin level driven by software still captures
// - Compare match sets flag on timer tick
// - Compare flag raises irq; ack or W1C clears
// - Compare A value exported as counter TOP
// - Compare double buffered in PWM, updated at TOP/BOTTOM
// - Host reaches buffer in PWM, compare otherwise
// - Compare high read returns register, not latch
// - Compare low write commits latch as high byte
// - Force strobe acts like match outside PWM modes, no flag
// - Counter write blocks matches on next tick
// - Output states kept across waveform mode change
// - Output mode field takes effect immediately
// - Output mode zero means no action
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module tcc_capture_compare (
    input wire logic clock,
    input wire logic reset,
    input wire tcc_pkg::tcc_bus_req_t bus_req,
    output logic [7:0] read_data,
    input wire logic capture_pin,
    input wire logic comparator_output,
    input wire logic [15:0] timer_count,
    input wire logic timer_tick,
    input wire logic at_top,
    input wire logic at_bottom,
    input wire logic counter_write,
    input wire logic capture_irq_ack,
    input wire logic [1:0] compare_irq_ack,
    output logic capture_irq,
    output logic [1:0] compare_irq,
    output logic [1:0] compare_output_state,
    output logic [1:0] compare_match,
    output logic [15:0] capture_top_value,
    output logic [15:0] compare_a_top_value
);
    // Host-written control state
    logic [7:0] out_ctrl_reg;
    logic [7:0] capt_ctrl_reg;
    logic [7:0] irq_mask_reg;
    logic trig_sel_reg;
    logic [7:0] temp_reg;
    logic [15:0] capture_reg;
    logic [2:0] flags_reg;
    logic [2:0] flags_next;
    logic block_reg;

    // Capture path state
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    localparam int FILTER_LEN_M1 = tcc_pkg::FILTER_SAMPLES - 2;
    logic [FILTER_LEN_M1:0] sample_reg;
    logic filt_reg;
    logic prev_reg;

    // Compare path state
    logic [15:0] compare_reg [tcc_pkg::NUM_COMPARE];
    logic [15:0] buffer_reg [tcc_pkg::NUM_COMPARE];
    logic [15:0] host_view [tcc_pkg::NUM_COMPARE];
    logic [1:0] match_hit;
    logic [1:0] force_hit;
    logic [1:0] state_reg;

    // Decoded mode and bus terms
    logic [3:0] wave_mode;
    logic pwm_mode;
    logic capt_top_mode;
    logic update_point;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic mux_level;
    logic filter_on;
    logic edge_level;
    logic capture_fire;
    logic [2:0] flag_clear;

    assign wr = bus_req.write_strobe;
    assign rd = bus_req.read_strobe;
    assign addr = bus_req.addr;
    assign wdata = bus_req.wdata;
    assign wave_mode = capt_ctrl_reg[3:0];
    assign pwm_mode = tcc_pkg::PWM_MODE_MASK[wave_mode];
    assign capt_top_mode = tcc_pkg::CAPT_TOP_MODE_MASK[wave_mode];
    assign filter_on = capt_ctrl_reg[tcc_pkg::CAPT_CTRL_FILTER_BIT];
    // Phase-and-frequency modes reload at BOTTOM, all other PWM at TOP
    assign update_point = timer_tick && (tcc_pkg::BOTTOM_UPDATE_MASK[wave_mode] ? at_bottom : at_top);

    // Control registers; mode changes touch no output state
    always_ff @(posedge clock) begin
        if (reset) begin
            out_ctrl_reg <= tcc_pkg::BYTE_RESET;
            capt_ctrl_reg <= tcc_pkg::BYTE_RESET;
            irq_mask_reg <= tcc_pkg::BYTE_RESET;
            trig_sel_reg <= 1'b0;
        end else if (wr) begin
            if (addr == tcc_pkg::ADDR_OUT_CTRL) begin
                out_ctrl_reg <= wdata;
            end
            if (addr == tcc_pkg::ADDR_CAPT_CTRL) begin
                capt_ctrl_reg <= wdata;
            end
            if (addr == tcc_pkg::ADDR_IRQ_MASK) begin
                irq_mask_reg <= wdata;
            end
            if (addr == tcc_pkg::ADDR_TRIG_SEL) begin
                trig_sel_reg <= wdata[0];
            end
        end
    end

    // Two-stage synchronisers, one per trigger source
    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_sync
            always_ff @(posedge clock) begin
                if (reset) begin
                    sync1_reg[s] <= 1'b0;
                    sync2_reg[s] <= 1'b0;
                end else begin
                    sync1_reg[s] <= (s == 0) ? capture_pin : comparator_output;
                    sync2_reg[s] <= sync1_reg[s];
                end
            end
        end
    endgenerate

    // Switching source may look like an edge; software clears the flag
    assign mux_level = trig_sel_reg ? sync2_reg[1] : sync2_reg[0];

    // Noise filter on system clock, independent of the prescaler
    always_ff @(posedge clock) begin
        if (reset) begin
            sample_reg <= '0;
            filt_reg <= 1'b0;
        end else begin
            sample_reg <= {sample_reg[FILTER_LEN_M1-1:0], mux_level};
            if (&{sample_reg, mux_level} || ~|{sample_reg, mux_level}) begin
                filt_reg <= mux_level;
            end
        end
    end

    assign edge_level = filter_on ? filt_reg : mux_level;

    // Edge detector stays live in every mode; capture-TOP modes only gate the fire
    always_ff @(posedge clock) begin
        if (reset) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= edge_level;
        end
    end

    assign capture_fire = !capt_top_mode && (edge_level != prev_reg) &&
                          (edge_level == capt_ctrl_reg[tcc_pkg::CAPT_CTRL_EDGE_BIT]);

    // Capture register: events always overwrite, host writes only as TOP
    always_ff @(posedge clock) begin
        if (reset) begin
            capture_reg <= tcc_pkg::WORD_RESET;
        end else if (capture_fire) begin
            capture_reg <= timer_count;
        end else if (wr && addr == tcc_pkg::ADDR_CAPT_L && capt_top_mode) begin
            capture_reg <= {temp_reg, wdata};
        end
    end

    // Shared high-byte latch
    always_ff @(posedge clock) begin
        if (reset) begin
            temp_reg <= tcc_pkg::BYTE_RESET;
        end else if (rd && addr == tcc_pkg::ADDR_CAPT_L) begin
            temp_reg <= capture_reg[15:8];
        end else if (wr && (addr == tcc_pkg::ADDR_CAPT_H || addr == tcc_pkg::ADDR_CMPA_H ||
                            addr == tcc_pkg::ADDR_CMPB_H)) begin
            temp_reg <= wdata;
        end
    end

    // Counter writes arm a one-tick match block, held while stopped
    always_ff @(posedge clock) begin
        if (reset) begin
            block_reg <= 1'b0;
        end else if (counter_write) begin
            block_reg <= 1'b1;
        end else if (timer_tick) begin
            block_reg <= 1'b0;
        end
    end

    // Per compare channel: registers, buffer, match and output state
    genvar c;
    generate
        for (c = 0; c < tcc_pkg::NUM_COMPARE; c++) begin : g_cmp
            localparam logic [7:0] LO_ADDR = tcc_pkg::ADDR_CMPA_L + 8'(c) * tcc_pkg::ADDR_CMP_STEP;
            logic low_write;
            logic [1:0] om;
            logic act;
            assign low_write = wr && addr == LO_ADDR;
            assign om = out_ctrl_reg[2*c+1 -: 2];
            assign host_view[c] = pwm_mode ? buffer_reg[c] : compare_reg[c];
            assign match_hit[c] = timer_tick && !block_reg && timer_count == compare_reg[c];
            assign force_hit[c] = wr && addr == tcc_pkg::ADDR_FORCE && wdata[c] && !pwm_mode;
            assign act = match_hit[c] || force_hit[c];

            always_ff @(posedge clock) begin
                if (reset) begin
                    buffer_reg[c] <= tcc_pkg::WORD_RESET;
                end else if (low_write && pwm_mode) begin
                    buffer_reg[c] <= {temp_reg, wdata};
                end
            end

            // Direct write in normal and clear-on-match, reload in PWM
            always_ff @(posedge clock) begin
                if (reset) begin
                    compare_reg[c] <= tcc_pkg::WORD_RESET;
                end else if (low_write && !pwm_mode) begin
                    compare_reg[c] <= {temp_reg, wdata};
                end else if (pwm_mode && update_point) begin
                    compare_reg[c] <= buffer_reg[c];
                end
            end

            // Output state follows the mode field in force at the event
            always_ff @(posedge clock) begin
                if (reset) begin
                    state_reg[c] <= 1'b0;
                end else if (act) begin
                    unique case (om)
                        tcc_pkg::OM_NONE: state_reg[c] <= state_reg[c];
                        tcc_pkg::OM_TOGGLE: state_reg[c] <= !state_reg[c];
                        tcc_pkg::OM_CLEAR: state_reg[c] <= 1'b0;
                        tcc_pkg::OM_SET: state_reg[c] <= 1'b1;
                    endcase
                end else if (pwm_mode && timer_tick && at_bottom) begin
                    // PWM period start restores the level opposite to the match action
                    if (om == tcc_pkg::OM_CLEAR) begin
                        state_reg[c] <= 1'b1;
                    end else if (om == tcc_pkg::OM_SET) begin
                        state_reg[c] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clock) begin
                if (reset) begin
                    compare_match[c] <= 1'b0;
                end else begin
                    compare_match[c] <= match_hit[c];
                end
            end
        end
    endgenerate

    // Sticky flags: a set in the clearing cycle wins
    assign flag_clear = ((wr && addr == tcc_pkg::ADDR_FLAGS) ? wdata[2:0] : 3'h0) |
                        {compare_irq_ack, capture_irq_ack};
    assign flags_next = (flags_reg & ~flag_clear) | {match_hit, capture_fire};

    always_ff @(posedge clock) begin
        if (reset) begin
            flags_reg <= 3'h0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Interrupt requests gated by enables
    always_ff @(posedge clock) begin
        if (reset) begin
            capture_irq <= 1'b0;
            compare_irq <= 2'h0;
        end else begin
            capture_irq <= flags_reg[tcc_pkg::FLAG_CAPTURE_BIT] & irq_mask_reg[0];
            compare_irq <= flags_reg[2:1] & irq_mask_reg[2:1];
        end
    end

    // Outputs toward counter and waveform logic
    always_ff @(posedge clock) begin
        if (reset) begin
            compare_output_state <= 2'h0;
            capture_top_value <= tcc_pkg::WORD_RESET;
            compare_a_top_value <= tcc_pkg::WORD_RESET;
        end else begin
            compare_output_state <= state_reg;
            capture_top_value <= capture_reg;
            compare_a_top_value <= compare_reg[0];
        end
    end

    // Read port; data valid the cycle after the strobe, zero elsewhere
    always_ff @(posedge clock) begin
        if (reset) begin
            read_data <= tcc_pkg::BYTE_RESET;
        end else if (rd) begin
            unique case (addr)
                tcc_pkg::ADDR_CAPT_L: read_data <= capture_reg[7:0];
                tcc_pkg::ADDR_CAPT_H: read_data <= temp_reg;
                tcc_pkg::ADDR_CMPA_L: read_data <= host_view[0][7:0];
                tcc_pkg::ADDR_CMPA_H: read_data <= host_view[0][15:8];
                tcc_pkg::ADDR_CMPB_L: read_data <= host_view[1][7:0];
                tcc_pkg::ADDR_CMPB_H: read_data <= host_view[1][15:8];
                tcc_pkg::ADDR_OUT_CTRL: read_data <= out_ctrl_reg;
                tcc_pkg::ADDR_CAPT_CTRL: read_data <= capt_ctrl_reg;
                tcc_pkg::ADDR_IRQ_MASK: read_data <= irq_mask_reg;
                tcc_pkg::ADDR_FLAGS: read_data <= {5'h00, flags_reg};
                tcc_pkg::ADDR_TRIG_SEL: read_data <= {7'h00, trig_sel_reg};
                tcc_pkg::ADDR_OUT_STATE: read_data <= {6'h00, state_reg};
                default: read_data <= tcc_pkg::BYTE_RESET;
            endcase
        end else begin
            read_data <= tcc_pkg::BYTE_RESET;
        end
    end

    // Checks next to the logic they guard
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_high_write(logic [7:0] a);
        wr && addr == a;
    endsequence

    sequence s_low_write(logic [7:0] a);
        wr && addr == a;
    endsequence

    capture_copy_a: assert property (capture_fire |=> capture_reg == $past(timer_count))
        else $error("capture did not copy counter");
    capture_flag_a: assert property (capture_fire |=> flags_reg[0])
        else $error("capture flag not set with copy");
    capture_irq_a: assert property (flags_reg[0] && irq_mask_reg[0] |=> capture_irq)
        else $error("capture irq missing");
    latch_read_a: assert property (rd && addr == tcc_pkg::ADDR_CAPT_L ##1 rd && addr == tcc_pkg::ADDR_CAPT_H
                                   |=> read_data == $past(capture_reg[15:8], 2))
        else $error("capture high read not from latch");
    capture_lock_a: assert property (wr && addr == tcc_pkg::ADDR_CAPT_L && !capt_top_mode && !capture_fire
                                     |=> $stable(capture_reg))
        else $error("capture written outside top mode");
    top_disable_a: assert property (capt_top_mode && !(wr && addr == tcc_pkg::ADDR_CAPT_L) |=> $stable(capture_reg))
        else $error("capture fired in top mode");
    filter_hold_a: assert property (filter_on && $changed(filt_reg) |-> $past(mux_level) == filt_reg &&
                                    $past(mux_level, 2) == filt_reg && $past(mux_level, 3) == filt_reg)
        else $error("filter changed early");
    compare_flag_a: assert property (match_hit[0] |=> flags_reg[1] ##0 compare_match[0])
        else $error("compare flag not set");
    match_block_a: assert property (counter_write ##1 (timer_tick && !counter_write) |-> !match_hit[0] && !match_hit[1])
        else $error("match not blocked after counter write");
    force_flag_a: assert property (force_hit[1] && !match_hit[1] && !flags_reg[2] && !timer_tick |=> !flags_reg[2])
        else $error("force set the flag");
    buffered_write_a: assert property (s_high_write(tcc_pkg::ADDR_CMPA_H) ##1 (s_low_write(tcc_pkg::ADDR_CMPA_L) && pwm_mode)
                                       |=> buffer_reg[0] == {$past(wdata, 2), $past(wdata)})
        else $error("buffer not loaded from latch");
    direct_write_a: assert property (s_high_write(tcc_pkg::ADDR_CMPB_H) ##1 (s_low_write(tcc_pkg::ADDR_CMPB_L) && !pwm_mode)
                                     |=> compare_reg[1] == {$past(wdata, 2), $past(wdata)})
        else $error("compare not written directly");
    reload_a: assert property (pwm_mode && update_point && !(wr && addr == tcc_pkg::ADDR_CMPA_L)
                               |=> compare_reg[0] == $past(buffer_reg[0]))
        else $error("buffer not reloaded at update point");
    no_action_a: assert property (out_ctrl_reg[1:0] == tcc_pkg::OM_NONE && !(pwm_mode && at_bottom) |=> $stable(state_reg[0]))
        else $error("output state moved with mode zero");
endmodule

`default_nettype wire

/* File: hdl/tcc_pkg.sv */
// Shared constants and bus carrier for the timer capture and compare block
package tcc_pkg;
    // Register indices on the plain 8-bit register port
    localparam logic [7:0] ADDR_CAPT_L = 8'h00;
    localparam logic [7:0] ADDR_CAPT_H = 8'h01;
    localparam logic [7:0] ADDR_CMPA_L = 8'h02;
    localparam logic [7:0] ADDR_CMPA_H = 8'h03;
    localparam logic [7:0] ADDR_CMPB_L = 8'h04;
    localparam logic [7:0] ADDR_CMPB_H = 8'h05;
    localparam logic [7:0] ADDR_CMP_STEP = 8'h02;
    localparam logic [7:0] ADDR_OUT_CTRL = 8'h06;
    localparam logic [7:0] ADDR_CAPT_CTRL = 8'h07;
    localparam logic [7:0] ADDR_FORCE = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h09;
    localparam logic [7:0] ADDR_FLAGS = 8'h0a;
    localparam logic [7:0] ADDR_TRIG_SEL = 8'h0b;
    localparam logic [7:0] ADDR_OUT_STATE = 8'h0c;

    // Field positions
    localparam int CAPT_CTRL_FILTER_BIT = 7;
    localparam int CAPT_CTRL_EDGE_BIT = 6;
    localparam int FLAG_CAPTURE_BIT = 0;
    localparam int FLAG_COMPARE_LSB = 1;
    localparam int NUM_COMPARE = 2;
    localparam int FILTER_SAMPLES = 4;

    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // Mode classes, one bit per waveform mode
    localparam logic [15:0] PWM_MODE_MASK = 16'hcfee;
    localparam logic [15:0] CAPT_TOP_MODE_MASK = 16'h5500;
    localparam logic [15:0] BOTTOM_UPDATE_MASK = 16'h0300;

    // Output mode field codes
    localparam logic [1:0] OM_NONE = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write_strobe;
        logic read_strobe;
    } tcc_bus_req_t;
endpackage
